// ==== core/ddr2_timing_pkg.sv ====
// shared constants for the ddr2 command timing gate
package ddr2_timing_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] TIMING_OFS = 8'h00;
  localparam logic [7:0] CONFIG_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // timing register field positions
  localparam int RFC_MSB = 31;
  localparam int RFC_LSB = 25;
  localparam int RP_MSB = 24;
  localparam int RP_LSB = 22;
  localparam int RCD_MSB = 21;
  localparam int RCD_LSB = 19;
  localparam int WR_MSB = 18;
  localparam int WR_LSB = 16;
  localparam int RAS_MSB = 15;
  localparam int RAS_LSB = 11;
  localparam int RC_MSB = 10;
  localparam int RC_LSB = 6;
  localparam int RRD_MSB = 5;
  localparam int RRD_LSB = 3;
  localparam int WTR_MSB = 1;
  localparam int WTR_LSB = 0;

  // timing register reset value and writable bits (bit 2 unused)
  localparam logic [31:0] TIMING_RST = 32'h7fff_fffb;
  localparam logic [31:0] TIMING_WMASK = 32'hffff_fffb;

  // config register bit positions and reset values
  localparam int UNLOCK_BIT = 0;
  localparam int ENABLE_BIT = 1;
  localparam logic UNLOCK_RST = 1'b0;
  localparam logic ENABLE_RST = 1'b0;

  // status register bit positions
  localparam int PEND_BIT = 0;
  localparam int BUSY_BIT = 1;

  // command kinds offered by the scheduler
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_REFRESH = 3'h1,
    CMD_MODE_LOAD = 3'h3,
    CMD_ACTIVATE = 3'h2,
    CMD_READ = 3'h6,
    CMD_WRITE = 3'h7,
    CMD_PRECHARGE = 3'h5
  } cmd_kind_t;

endpackage : ddr2_timing_pkg

// ==== core/spacing_counter.sv ====
// down-counter that holds off one kind of command after another
module spacing_counter #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // load on the command or write data beat that opens the gap
  input wire logic load,
  input wire logic [W-1:0] value,
  // gap state
  output logic [W-1:0] count,
  output logic zero
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } cnt_state_t;

  cnt_state_t s_q;
  cnt_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (rst)
    begin
      s_d.cnt = '0;
    end
    else if (load)
    begin
      s_d.cnt = value;
    end
    else if (s_q.cnt != '0)
    begin
      s_d.cnt = s_q.cnt - W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    s_q <= s_d;
  end

  assign count = s_q.cnt;
  assign zero = (s_q.cnt == '0);

  a_count_down: assert property (@(posedge clk) disable iff (rst)
    !load && count != '0 |=> count == $past(count) - W'(1))
    else $error("spacing counter did not step down");

endmodule : spacing_counter

// ==== core/ddr2_command_timing_gate.sv ====
// ddr2 timing register with apb access and command spacing gate
//
// The register offsets and the APB interface to the registers were left to the implementer.
module ddr2_command_timing_gate
  import ddr2_timing_pkg::*;
#(
  parameter int NBANK = 8,
  parameter int BANK_W = 3
) (
  // system clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory clock domain
  input wire logic mem_clk,
  // command offer from the scheduler, and last write beat from the memory
  input wire logic cmd_req,
  input wire ddr2_timing_pkg::cmd_kind_t cmd_kind,
  input wire logic [BANK_W-1:0] cmd_bank,
  input wire logic wr_last_data,
  output logic cmd_grant,
  // start of sdram initialisation
  output logic init_start
);

  import ddr2_timing_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // system clock side: registers and update launch

  typedef struct packed {
    logic [31:0] timing;
    logic unlock;
    logic enable;
    logic [31:0] rdata;
    logic slverr;
    logic pend;
    logic init_pend;
    logic busy;
    logic req_tog;
    logic [32:0] shadow;
    logic ack_s1;
    logic ack_s2;
  } sys_state_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic ack_tog;
    logic [31:0] timing;
    logic init;
  } link_state_t;

  sys_state_t m_q;
  sys_state_t m_d;
  link_state_t l_q;
  link_state_t l_d;

  logic setup;
  logic access;
  logic [31:0] new_timing;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign new_timing = pwdata & TIMING_WMASK;

  always_comb
  begin
    m_d = m_q;
    m_d.ack_s1 = l_q.ack_tog;
    m_d.ack_s2 = m_q.ack_s1;
    if (m_q.busy && m_q.ack_s2 == m_q.req_tog)
    begin
      m_d.busy = 1'b0;
    end
    // shadow is frozen while busy, so the link side reads it stable
    if (m_q.pend && !m_q.busy)
    begin
      m_d.shadow = {m_q.init_pend, m_q.timing};
      m_d.req_tog = !m_q.req_tog;
      m_d.busy = 1'b1;
      m_d.pend = 1'b0;
      m_d.init_pend = 1'b0;
    end
    if (setup)
    begin
      m_d.slverr = 1'b0;
      if (paddr == TIMING_OFS)
      begin
        m_d.rdata = m_q.timing;
      end
      else if (paddr == CONFIG_OFS)
      begin
        m_d.rdata = '0;
        m_d.rdata[UNLOCK_BIT] = m_q.unlock;
        m_d.rdata[ENABLE_BIT] = m_q.enable;
      end
      else if (paddr == STATUS_OFS)
      begin
        m_d.rdata = '0;
        m_d.rdata[PEND_BIT] = m_q.pend;
        m_d.rdata[BUSY_BIT] = m_q.busy;
      end
      else
      begin
        m_d.rdata = '0;
        m_d.slverr = 1'b1;
      end
    end
    // a write landing with the launch sets pend again: set wins
    if (access && pwrite)
    begin
      if (paddr == TIMING_OFS)
      begin
        if (m_q.unlock)
        begin
          m_d.timing = new_timing;
          m_d.pend = 1'b1;
          if (m_q.enable &&
              new_timing[WR_MSB:WR_LSB] != m_q.timing[WR_MSB:WR_LSB])
          begin
            m_d.init_pend = 1'b1;
          end
        end
      end
      else if (paddr == CONFIG_OFS)
      begin
        m_d.unlock = pwdata[UNLOCK_BIT];
        m_d.enable = pwdata[ENABLE_BIT];
      end
    end
    if (rst)
    begin
      m_d = '0;
      m_d.timing = TIMING_RST;
      m_d.unlock = UNLOCK_RST;
      m_d.enable = ENABLE_RST;
    end
  end

  always_ff @(posedge mclk)
  begin
    m_q <= m_d;
  end

  assign prdata = m_q.rdata;
  assign pready = access;
  assign pslverr = access && m_q.slverr;

  ////////////////////////////////////////////////////////////////////////////
  // memory clock side: field copy and command gate

  logic rst_l;
  assign rst_l = l_q.rst_s2;

  always_comb
  begin
    l_d = l_q;
    l_d.init = 1'b0;
    if (rst_l)
    begin
      l_d.ack_tog = 1'b0;
      l_d.timing = TIMING_RST;
    end
    else if (l_q.req_s2 != l_q.ack_tog)
    begin
      l_d.timing = m_q.shadow[31:0];
      l_d.init = m_q.shadow[32];
      l_d.ack_tog = !l_q.ack_tog;
    end
    l_d.rst_s1 = rst;
    l_d.rst_s2 = l_q.rst_s1;
    l_d.req_s1 = m_q.req_tog;
    l_d.req_s2 = l_q.req_s1;
  end

  always_ff @(posedge mem_clk)
  begin
    l_q <= l_d;
  end

  assign init_start = l_q.init;

  logic is_ref;
  logic is_act;
  logic is_rd;
  logic is_wr;
  logic is_pre;
  assign is_ref = cmd_kind == CMD_REFRESH || cmd_kind == CMD_MODE_LOAD;
  assign is_act = cmd_kind == CMD_ACTIVATE;
  assign is_rd = cmd_kind == CMD_READ;
  assign is_wr = cmd_kind == CMD_WRITE;
  assign is_pre = cmd_kind == CMD_PRECHARGE;

  logic [6:0] rfc_cnt;
  logic rfc_zero;
  logic rp_zero;
  logic wr_zero;
  logic rrd_zero;
  logic wtr_zero;
  logic [NBANK-1:0] rcd_zero;
  logic [NBANK-1:0] ras_zero;
  logic [NBANK-1:0] rc_zero;
  logic [NBANK-1:0] act_bank;

  spacing_counter #(.W(7)) u_rfc (
    .clk(mem_clk), .rst(rst_l),
    .load(cmd_grant && is_ref),
    .value(l_q.timing[RFC_MSB:RFC_LSB]),
    .count(rfc_cnt), .zero(rfc_zero));

  spacing_counter #(.W(3)) u_rp (
    .clk(mem_clk), .rst(rst_l),
    .load(cmd_grant && is_pre),
    .value(l_q.timing[RP_MSB:RP_LSB]),
    .count(), .zero(rp_zero));

  spacing_counter #(.W(3)) u_wr (
    .clk(mem_clk), .rst(rst_l),
    .load(wr_last_data),
    .value(l_q.timing[WR_MSB:WR_LSB]),
    .count(), .zero(wr_zero));

  spacing_counter #(.W(3)) u_rrd (
    .clk(mem_clk), .rst(rst_l),
    .load(cmd_grant && is_act),
    .value(l_q.timing[RRD_MSB:RRD_LSB]),
    .count(), .zero(rrd_zero));

  spacing_counter #(.W(2)) u_wtr (
    .clk(mem_clk), .rst(rst_l),
    .load(wr_last_data),
    .value(l_q.timing[WTR_MSB:WTR_LSB]),
    .count(), .zero(wtr_zero));

  genvar b;
  generate
    for (b = 0; b < NBANK; b++)
    begin : g_bank
      assign act_bank[b] = cmd_grant && is_act &&
                           cmd_bank == BANK_W'(b);
      spacing_counter #(.W(3)) u_rcd (
        .clk(mem_clk), .rst(rst_l),
        .load(act_bank[b]),
        .value(l_q.timing[RCD_MSB:RCD_LSB]),
        .count(), .zero(rcd_zero[b]));
      spacing_counter #(.W(5)) u_ras (
        .clk(mem_clk), .rst(rst_l),
        .load(act_bank[b]),
        .value(l_q.timing[RAS_MSB:RAS_LSB]),
        .count(), .zero(ras_zero[b]));
      spacing_counter #(.W(5)) u_rc (
        .clk(mem_clk), .rst(rst_l),
        .load(act_bank[b]),
        .value(l_q.timing[RC_MSB:RC_LSB]),
        .count(), .zero(rc_zero[b]));
    end
  endgenerate

  // rrd is applied to every activate; rc normally exceeds it anyway
  logic allowed;
  always_comb
  begin
    allowed = 1'b0;
    if (is_ref)
    begin
      allowed = rfc_zero && rp_zero;
    end
    else if (is_act)
    begin
      allowed = rfc_zero && rp_zero && rrd_zero &&
                rc_zero[cmd_bank];
    end
    else if (is_rd)
    begin
      // the gap counts from the data beat itself, not only after its load
      allowed = rcd_zero[cmd_bank] && wtr_zero &&
                !wr_last_data;
    end
    else if (is_wr)
    begin
      allowed = rcd_zero[cmd_bank];
    end
    else if (is_pre)
    begin
      allowed = ras_zero[cmd_bank] && wr_zero &&
                !wr_last_data;
    end
  end

  assign cmd_grant = cmd_req && allowed && !rst_l;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_rfc_load: assert property (@(posedge mem_clk) disable iff (rst_l)
    cmd_grant && is_ref |=> rfc_cnt == $past(l_q.timing[RFC_MSB:RFC_LSB]))
    else $error("rfc gap not loaded from field");
  a_act_after_ref: assert property (@(posedge mem_clk) disable iff (rst_l)
    cmd_grant && (is_act || is_ref) |-> rfc_zero && rp_zero)
    else $error("refresh or activate granted inside gap");
  a_rcd_hold: assert property (@(posedge mem_clk) disable iff (rst_l)
    cmd_grant && (is_rd || is_wr) |-> rcd_zero[cmd_bank])
    else $error("column command too soon after activate");
  a_pre_gap: assert property (@(posedge mem_clk) disable iff (rst_l)
    cmd_grant && is_pre |-> ras_zero[cmd_bank] && wr_zero)
    else $error("precharge too early");
  a_act_spacing: assert property (@(posedge mem_clk) disable iff (rst_l)
    cmd_grant && is_act |-> rrd_zero && rc_zero[cmd_bank])
    else $error("activate spacing broken");
  a_wtr_gap: assert property (@(posedge mem_clk) disable iff (rst_l)
    cmd_grant && is_rd |-> wtr_zero)
    else $error("read too soon after write");
  a_wr_beat_gap: assert property (@(posedge mem_clk) disable iff (rst_l)
    cmd_grant && (is_pre || is_rd) |-> !wr_last_data)
    else $error("precharge or read during last write beat");
  a_rsvd_zero: assert property (@(posedge mclk) disable iff (rst)
    access && !pwrite && paddr == TIMING_OFS |-> prdata[2] == 1'b0)
    else $error("unused timing bit reads one");
  a_lock_hold: assert property (@(posedge mclk) disable iff (rst)
    access && pwrite && paddr == TIMING_OFS && !m_q.unlock
    |=> m_q.timing == $past(m_q.timing))
    else $error("locked timing register changed");
  a_init_req: assert property (@(posedge mclk) disable iff (rst)
    access && pwrite && paddr == TIMING_OFS && m_q.unlock && m_q.enable &&
    new_timing[WR_MSB:WR_LSB] != m_q.timing[WR_MSB:WR_LSB]
    |=> m_q.init_pend ##[0:40] m_q.shadow[32])
    else $error("wr change did not request init");

  c_refresh: cover property (@(posedge mem_clk) cmd_grant && is_ref);
  c_act_blocked: cover property (@(posedge mem_clk)
    cmd_req && is_act && !cmd_grant);
  c_init: cover property (@(posedge mem_clk) init_start);
  c_locked_write: cover property (@(posedge mclk)
    access && pwrite && paddr == TIMING_OFS && !m_q.unlock);

endmodule : ddr2_command_timing_gate

// ==== verification/sdram_model.sv ====
// memory-side model that marks the last write data beat
module sdram_model
  import ddr2_timing_pkg::*;
(
  // memory clock and reset
  input wire logic mem_clk,
  input wire logic rst,
  // command seen on the memory bus
  input wire logic cmd_req,
  input wire ddr2_timing_pkg::cmd_kind_t cmd_kind,
  input wire logic cmd_grant,
  // end of the write data burst
  output logic wr_last_data
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic wr_seen = cmd_req && cmd_grant && (cmd_kind == CMD_WRITE);
  // one-beat bursts: the last beat follows its write command at once
  always_ff @(posedge mem_clk)
  begin
    if (rst)
      wr_last_data <= 1'b0;
    else
      wr_last_data <= wr_seen;
  end
endmodule : sdram_model

// ==== verification/ddr2_command_timing_gate_tb.sv ====
// self-checking bench for the ddr2 command timing gate
`define CHK(a, b) \
  begin \
    samples_checked++; \
    if ((a) !== (b)) \
    begin \
      errors++; \
      $display("FAIL t=%0t got %h exp %h", $time, a, b); \
    end \
  end
module ddr2_command_timing_gate_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ddr2_timing_pkg::*;
  logic mclk = 1'b0;
  logic mem_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cmd_req = 1'b0;
  cmd_kind_t cmd_kind = CMD_NOP;
  logic [2:0] cmd_bank = 3'h0;
  logic wr_last_data;
  logic cmd_grant;
  logic init_start;
  int errors = 0;
  int samples_checked = 0;
  int inits = 0;
  logic [31:0] rd;
  logic er;
  always #10 mclk = ~mclk;
  always #24 mem_clk = ~mem_clk;
  always @(posedge mem_clk)
    if (init_start === 1'b1)
      inits <= inits + 1;
  ddr2_command_timing_gate ddr2_command_timing_gate_inst (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_clk(mem_clk),
    .cmd_req(cmd_req), .cmd_kind(cmd_kind), .cmd_bank(cmd_bank),
    .wr_last_data(wr_last_data), .cmd_grant(cmd_grant),
    .init_start(init_start)
  );
  sdram_model sdram_model_inst (
    .mem_clk(mem_clk), .rst(rst), .cmd_req(cmd_req),
    .cmd_kind(cmd_kind), .cmd_grant(cmd_grant),
    .wr_last_data(wr_last_data)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      errors++;
      summarize();
    end
  endtask : apb
  // called just after a mem_clk edge; leaves the request up
  task automatic offer(input cmd_kind_t k, input logic [2:0] b,
                       output int n);
    cmd_req <= 1'b1;
    cmd_kind <= k;
    cmd_bank <= b;
    n = 0;
    @(negedge mem_clk);
    while (cmd_grant !== 1'b1 && n < 40)
    begin
      n++;
      @(negedge mem_clk);
    end
    @(posedge mem_clk);
  endtask : offer
  // idle long enough that every earlier gap has run out
  task automatic gap(input cmd_kind_t ka, input logic [2:0] ba,
                     input cmd_kind_t kb, input logic [2:0] bb,
                     input int exp);
    int n;
    repeat (12) @(posedge mem_clk);
    offer(ka, ba, n);
    offer(kb, bb, n);
    cmd_req <= 1'b0;
    `CHK(n, exp)
    if (n >= 40)
      summarize();
  endtask : gap
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, TIMING_OFS, 32'h0);
    `CHK(rd, TIMING_RST)
    apb(1'b0, CONFIG_OFS, 32'h0);
    `CHK(rd, 32'h0000_0000)
    apb(1'b1, TIMING_OFS, 32'h0ad4_31ce);
    apb(1'b0, TIMING_OFS, 32'h0);
    `CHK(rd, TIMING_RST)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
    apb(1'b1, CONFIG_OFS, 32'h1);
    // rfc 5 rp 3 rcd 2 wr 4 ras 6 rc 7 rrd 1 wtr 2, bit 2 set
    apb(1'b1, TIMING_OFS, 32'h0ad4_31ce);
    apb(1'b0, TIMING_OFS, 32'h0);
    `CHK(rd, 32'h0ad4_31ca)
    repeat (20) @(posedge mem_clk);
    `CHK(inits, 0)
    gap(CMD_REFRESH, 3'h0, CMD_ACTIVATE, 3'h0, 5);
    gap(CMD_MODE_LOAD, 3'h0, CMD_REFRESH, 3'h0, 5);
    gap(CMD_REFRESH, 3'h0, CMD_REFRESH, 3'h0, 5);
    gap(CMD_PRECHARGE, 3'h2, CMD_ACTIVATE, 3'h2, 3);
    gap(CMD_PRECHARGE, 3'h2, CMD_REFRESH, 3'h0, 3);
    gap(CMD_ACTIVATE, 3'h1, CMD_READ, 3'h1, 2);
    gap(CMD_ACTIVATE, 3'h1, CMD_WRITE, 3'h1, 2);
    gap(CMD_WRITE, 3'h4, CMD_PRECHARGE, 3'h4, 5);
    gap(CMD_ACTIVATE, 3'h3, CMD_PRECHARGE, 3'h3, 6);
    gap(CMD_ACTIVATE, 3'h0, CMD_ACTIVATE, 3'h0, 7);
    gap(CMD_ACTIVATE, 3'h0, CMD_ACTIVATE, 3'h5, 1);
    gap(CMD_WRITE, 3'h6, CMD_READ, 3'h6, 3);
    apb(1'b1, CONFIG_OFS, 32'h3);
    apb(1'b1, TIMING_OFS, 32'h0ad4_31ca);
    repeat (20) @(posedge mem_clk);
    `CHK(inits, 0)
    apb(1'b1, TIMING_OFS, 32'h0ad3_31ca);
    repeat (20) @(posedge mem_clk);
    `CHK(inits, 1)
    apb(1'b1, CONFIG_OFS, 32'h2);
    apb(1'b1, TIMING_OFS, 32'h0);
    apb(1'b0, TIMING_OFS, 32'h0);
    `CHK(rd, 32'h0ad3_31ca)
    repeat (20) @(posedge mem_clk);
    `CHK(inits, 1)
    summarize();
  end
endmodule : ddr2_command_timing_gate_tb
